/* File: design/pbc_ctrl_regs.sv */
// Summary of operation
// [RQ1] Reset and restart-negotiation bits clear themselves once their action is taken.
// [RQ2] Software reset outside power-down resets chip logic and relatches the straps.
// [RQ3] Power-down bit one means power-down mode; zero normal; resets to zero.
// [RQ4] Leaving power-down by reset needs two writes: first clears, second resets.
// [RQ5] Speed bit picks 100 or 10 Mbps; ignored while negotiation enabled.
// [RQ6] Speed bit reset value comes from the latched speed strap.
// [RQ7] Negotiation enabled uses resolved speed and duplex; disabled uses manual bits.
// [RQ8] Negotiation enable reset value comes from the latched negotiation strap.
// [RQ9] Writing one to restart bit restarts negotiation; zero does nothing. Code restarts only if the same write also sets negotiation enable.
// [RQ10] Isolate bit one isolates the PHY from MII; zero is normal.
// [RQ11] Isolate bit reset value comes from the latched isolation strap.
// [RQ12] Duplex bit one full, zero half; reset value inverts duplex strap.
// [RQ13] Collision test bit enables the collision output test; resets to zero.
// [RQ14] Status reads not T4 capable and 100 Mbps full-duplex capable.
// [RQ15] Status reads 100 Mbps half-duplex capable.
// [RQ16] Loop-back bit, reset zero, routes transmit data back to receive.
// [RQ17] Reserved low seven control bits read zero and ignore writes.
`timescale 1ns/1ps
module pbc_ctrl_regs
    import pbc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port from the management interface engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Strap pins, asynchronous
    input wire logic speed_strap,
    input wire logic negotiation_enable_strap,
    input wire logic isolate_strap,
    input wire logic duplex_strap,
    // Negotiation engine
    input wire logic aneg_done,
    input wire logic aneg_speed_100,
    input wire logic aneg_full_duplex,
    output logic aneg_enable,
    output logic aneg_restart,
    // Operating controls
    output logic chip_rst,
    output logic power_down,
    output logic mii_isolate,
    output logic loopback,
    output logic col_test,
    output logic speed_100,
    output logic full_duplex
);
    localparam logic [2:0] CHIP_RST_LEN = 3'(PBC_CHIP_RST_CYCLES);

    // Strap capture sits at count three, so shorter pulses cannot relatch in time
    if (PBC_CHIP_RST_CYCLES < 3 || PBC_CHIP_RST_CYCLES > 7) begin : g_bad_rst_len
        $error("chip reset length out of range");
    end

    typedef struct packed {
        logic loopback;
        logic speed;
        logic aneg_en;
        logic power_down;
        logic isolate;
        logic duplex;
        logic col_test;
        logic load_straps;
        logic [2:0] rst_cnt;
        logic chip_rst;
        logic aneg_restart;
        logic speed_eff;
        logic duplex_eff;
        logic [15:0] rdata;
        logic rvalid;
    } pbc_ctrl_state_t;

    pbc_ctrl_state_t st_q, st_d;

    logic [3:0] straps_sync;
    logic [3:0] straps;
    logic [15:0] control_view;
    logic sw_reset_wr;
    logic ctrl_wr;

    for (genvar i = 0; i < 4; i++) begin : g_sync
        pbc_sync2 u_sync (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .din(i == 0 ? speed_strap : i == 1 ? negotiation_enable_strap :
                 i == 2 ? isolate_strap : duplex_strap),
            .dout(straps_sync[i])
        );
    end

    // Capture late in the chip reset pulse, once the synchronisers hold the pins
    pbc_strap_latch u_straps (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .capture(st_q.load_straps),
        .straps_sync(straps_sync),
        .straps(straps)
    );

    always_comb begin
        control_view = 16'h0000;
        control_view[PBC_BIT_LOOPBACK] = st_q.loopback;
        control_view[PBC_BIT_SPEED] = st_q.speed;
        control_view[PBC_BIT_ANEG_EN] = st_q.aneg_en;
        control_view[PBC_BIT_POWER_DOWN] = st_q.power_down;
        control_view[PBC_BIT_ISOLATE] = st_q.isolate;
        control_view[PBC_BIT_DUPLEX] = st_q.duplex;
        control_view[PBC_BIT_COL_TEST] = st_q.col_test;
        control_view = control_view & ~PBC_CONTROL_RSVD_MASK; // RQ17
    end

    assign ctrl_wr = reg_wr && (reg_addr == PBC_ADDR_CONTROL);
    assign sw_reset_wr = ctrl_wr && reg_wdata[PBC_BIT_RESET];

    always_comb begin
        st_d = st_q;
        st_d.aneg_restart = 1'b0;
        st_d.rvalid = reg_rd;
        st_d.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == PBC_ADDR_CONTROL) begin
                // Reset and restart bits always read zero
                st_d.rdata = control_view; // RQ1
            end else if (reg_addr == PBC_ADDR_STATUS) begin
                st_d.rdata = PBC_STATUS_CAPS; // RQ14 RQ15
            end
        end

        // Chip reset pulse, then a strap reload at its end
        st_d.load_straps = 1'b0;
        if (st_q.rst_cnt != 3'd0) begin
            st_d.rst_cnt = st_q.rst_cnt - 3'd1;
            // Last count lowers the pulse so it spans exactly CHIP_RST_LEN cycles
            st_d.chip_rst = (st_q.rst_cnt != 3'd1);
            if (st_q.rst_cnt == 3'd3) begin
                // Latch output is settled before the bits load at pulse end
                st_d.load_straps = 1'b1; // RQ2
            end
        end else begin
            st_d.chip_rst = 1'b0;
        end

        // Strap-derived defaults taken the cycle after the latch updates
        if (st_q.chip_rst && !st_d.chip_rst) begin
            st_d.speed = straps[0]; // RQ6
            st_d.aneg_en = straps[1]; // RQ8
            st_d.isolate = straps[2]; // RQ11
            st_d.duplex = ~straps[3]; // RQ12
            st_d.loopback = PBC_RST_LOOPBACK;
            st_d.col_test = PBC_RST_COL_TEST; // RQ13
            st_d.power_down = PBC_RST_POWER_DOWN; // RQ3
        end

        if (ctrl_wr && !st_q.chip_rst) begin
            if (sw_reset_wr && st_q.power_down) begin
                // First reset write in power-down only leaves power-down
                st_d.power_down = 1'b0; // RQ4
            end else if (sw_reset_wr) begin
                // Self-clearing: the bit is never stored
                st_d.rst_cnt = CHIP_RST_LEN; // RQ1 RQ2 RQ4
                st_d.chip_rst = 1'b1;
            end else begin
                st_d.loopback = reg_wdata[PBC_BIT_LOOPBACK]; // RQ16
                st_d.speed = reg_wdata[PBC_BIT_SPEED];
                st_d.aneg_en = reg_wdata[PBC_BIT_ANEG_EN];
                st_d.power_down = reg_wdata[PBC_BIT_POWER_DOWN]; // RQ3
                st_d.isolate = reg_wdata[PBC_BIT_ISOLATE]; // RQ10
                st_d.duplex = reg_wdata[PBC_BIT_DUPLEX];
                st_d.col_test = reg_wdata[PBC_BIT_COL_TEST]; // RQ13
                // Restart is a one-cycle pulse and never stored
                st_d.aneg_restart = reg_wdata[PBC_BIT_ANEG_RESTART] &&
                                    reg_wdata[PBC_BIT_ANEG_EN]; // RQ9 RQ1
            end
        end

        // Negotiation overrides manual speed and duplex
        if (st_d.aneg_en) begin
            st_d.speed_eff = aneg_done ? aneg_speed_100 : st_q.speed_eff; // RQ5 RQ7
            st_d.duplex_eff = aneg_done ? aneg_full_duplex : st_q.duplex_eff; // RQ7
        end else begin
            st_d.speed_eff = st_d.speed; // RQ5
            st_d.duplex_eff = st_d.duplex; // RQ12
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= '0;
            // Hardware reset runs the same pulse so straps load after release
            st_q.rst_cnt <= CHIP_RST_LEN;
            st_q.chip_rst <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign reg_rvalid = st_q.rvalid;
    assign chip_rst = st_q.chip_rst;
    assign power_down = st_q.power_down; // RQ3
    assign mii_isolate = st_q.isolate; // RQ10
    assign loopback = st_q.loopback; // RQ16
    assign col_test = st_q.col_test; // RQ13
    assign aneg_enable = st_q.aneg_en; // RQ7
    assign aneg_restart = st_q.aneg_restart; // RQ9
    assign speed_100 = st_q.speed_eff;
    assign full_duplex = st_q.duplex_eff;
endmodule : pbc_ctrl_regs

/* File: design/pbc_pkg.sv */
package pbc_pkg;
    localparam logic [4:0] PBC_ADDR_CONTROL = 5'h00;
    localparam logic [4:0] PBC_ADDR_STATUS = 5'h01;
    localparam int PBC_BIT_RESET = 15;
    localparam int PBC_BIT_LOOPBACK = 14;
    localparam int PBC_BIT_SPEED = 13;
    localparam int PBC_BIT_ANEG_EN = 12;
    localparam int PBC_BIT_POWER_DOWN = 11;
    localparam int PBC_BIT_ISOLATE = 10;
    localparam int PBC_BIT_ANEG_RESTART = 9;
    localparam int PBC_BIT_DUPLEX = 8;
    localparam int PBC_BIT_COL_TEST = 7;
    localparam logic PBC_RST_LOOPBACK = 1'b0;
    localparam logic PBC_RST_POWER_DOWN = 1'b0;
    localparam logic PBC_RST_COL_TEST = 1'b0;
    localparam logic [15:0] PBC_STATUS_CAPS = 16'h6000;
    localparam logic [15:0] PBC_CONTROL_RSVD_MASK = 16'h007f;
    // Internal chip reset pulse length in mclk cycles
    localparam int PBC_CHIP_RST_CYCLES = 4;
endpackage : pbc_pkg

/* File: design/pbc_strap_latch.sv */
`timescale 1ns/1ps
module pbc_strap_latch (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic capture,
    input wire logic [3:0] straps_sync,
    output logic [3:0] straps
);
    typedef struct packed {
        logic [3:0] val;
    } pbc_strap_state_t;
    pbc_strap_state_t st_q, st_d;
    always_comb begin
        st_d = st_q;
        if (capture) begin
            st_d.val = straps_sync;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign straps = st_q.val;
endmodule : pbc_strap_latch

/* File: design/pbc_sync2.sv */
`timescale 1ns/1ps
module pbc_sync2 (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } pbc_sync_state_t;
    pbc_sync_state_t st_q, st_d;
    always_comb begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign dout = st_q.s2;
endmodule : pbc_sync2

/* File: test/pbc_aneg_model.sv */
`timescale 1ns/1ps
module pbc_aneg_model #(parameter int DELAY = 6) (
    input wire logic mclk,
    input wire logic aneg_restart,
    input wire logic res_speed,
    input wire logic res_duplex,
    output logic aneg_done,
    output logic aneg_speed_100,
    output logic aneg_full_duplex
);
    int cnt = 0;
    logic tgl = 1'b0;
    assign aneg_done = cnt == DELAY;
    // Unresolved results churn so no stale value can pass
    assign aneg_speed_100 = aneg_done ? res_speed : tgl;
    assign aneg_full_duplex = aneg_done ? res_duplex : ~tgl;
    always @(posedge mclk) begin
        tgl <= ~tgl;
        if (aneg_restart) cnt <= 0;
        else if (cnt < DELAY) cnt <= cnt + 1;
    end
endmodule : pbc_aneg_model

/* File: test/pbc_ctrl_regs_sva.sv */
`timescale 1ns/1ps
module pbc_ctrl_regs_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic aneg_enable,
    input wire logic aneg_restart,
    input wire logic chip_rst,
    input wire logic power_down,
    input wire logic mii_isolate,
    input wire logic loopback,
    input wire logic col_test,
    input wire logic speed_100,
    input wire logic full_duplex
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic wr0;
    logic [15:0] wd_q;
    assign wr0 = reg_wr && reg_addr == 5'h00 && !chip_rst;
    always_ff @(posedge mclk) wd_q <= reg_wdata;
    a_restart_pulse: assert property (aneg_restart |=> !aneg_restart) else $error("restart too long");
    a_restart_cause: assert property (aneg_restart |-> $past(wr0 && reg_wdata[9] && reg_wdata[12]))
        else $error("restart without write");
    a_status_read: assert property (reg_rd && reg_addr == 5'h01 |=> reg_rvalid && reg_rdata == 16'h6000)
        else $error("bad status read");
    a_rsvd_zero: assert property (reg_rvalid |-> reg_rdata[6:0] == 7'h00 && !reg_rdata[15] && !reg_rdata[9])
        else $error("reserved bits set");
    a_chip_rst_len: assert property ($rose(chip_rst) |-> chip_rst [*4] ##1 !chip_rst)
        else $error("chip reset length");
    a_ctrl_update: assert property (wr0 && !reg_wdata[15] |=> {loopback, power_down, mii_isolate, col_test,
        aneg_enable} == {wd_q[14], wd_q[11], wd_q[10], wd_q[7], wd_q[12]}) else $error("ctrl bits");
    a_manual_mode: assert property (wr0 && !reg_wdata[15] && !reg_wdata[12] |=> speed_100 == wd_q[13]
        && full_duplex == wd_q[8]) else $error("manual mode");
    a_pd_exit: assert property (wr0 && reg_wdata[15] && power_down |=> !power_down && !chip_rst)
        else $error("power-down exit");
    cover property (aneg_restart);
    cover property ($rose(chip_rst));
    cover property (wr0 && reg_wdata[15] && power_down);
endmodule : pbc_ctrl_regs_sva
bind pbc_ctrl_regs pbc_ctrl_regs_sva chk (.*);

/* File: test/phy_basic_control_status_regs_bench.sv */
`timescale 1ns/1ps
module phy_basic_control_status_regs_bench;
    import pbc_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    int n_restart = 0, restarts_before = 0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, ctl, d;
    logic speed_strap = 1'b0, negotiation_enable_strap = 1'b0, isolate_strap = 1'b0, duplex_strap = 1'b0;
    logic res_speed = 1'b0, res_duplex = 1'b0, reg_rvalid, aneg_done, aneg_speed_100, aneg_full_duplex;
    logic aneg_enable, aneg_restart, chip_rst, power_down, mii_isolate, loopback, col_test, speed_100, full_duplex;
    int n_mismatch = 0, comparisons = 0;
    pbc_ctrl_regs dut (.*);
    pbc_aneg_model partner (.*);
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (aneg_restart) n_restart <= n_restart + 1;
    function automatic logic [15:0] dflt();
        return {2'b00, speed_strap, negotiation_enable_strap, 1'b0, isolate_strap, 1'b0, ~duplex_strap, 8'h00};
    endfunction : dflt
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] v);
        reg_addr = PBC_ADDR_CONTROL;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        if (!v[15]) ctl = v & 16'h7d80;
        else if (ctl[11]) ctl[11] = 1'b0;
        else ctl = dflt();
        @(negedge mclk);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        chk(16'(reg_rvalid), 16'h0001);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic outs();
        chk(16'({loopback, power_down, mii_isolate, col_test, aneg_enable}),
            16'({ctl[14], ctl[11], ctl[10], ctl[7], ctl[12]}));
        if (!ctl[12]) chk(16'({speed_100, full_duplex}), 16'({ctl[13], ctl[8]}));
    endtask : outs
    initial begin
        #100us;
        n_mismatch++;
        complete_run();
    end
    initial begin
        void'($urandom(58));
        {speed_strap, negotiation_enable_strap, isolate_strap, duplex_strap} = 4'($urandom);
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        // Chip reset still runs after release; straps load at its end
        repeat (8) @(negedge mclk);
        ctl = dflt();
        rd(PBC_ADDR_CONTROL, ctl);
        outs();
        rd(PBC_ADDR_STATUS, PBC_STATUS_CAPS);
        rd(5'h1f, 16'h0000);
        $display("done defaults");
        for (int i = 0; i < 8; i++) begin
            d = 16'($urandom);
            d[15] = 1'b0;
            d[12] = 1'b0;
            wr(d);
            outs();
            rd(PBC_ADDR_CONTROL, ctl);
        end
        $display("done writes");
        {res_speed, res_duplex} = 2'($urandom);
        restarts_before = n_restart;
        wr(16'h1200);
        chk(16'(n_restart - restarts_before), 16'h0001);
        repeat (12) @(negedge mclk);
        chk(16'({speed_100, full_duplex}), 16'({res_speed, res_duplex}));
        rd(PBC_ADDR_CONTROL, ctl);
        $display("done restart");
        wr(16'h0800);
        outs();
        {speed_strap, negotiation_enable_strap, isolate_strap, duplex_strap} = 4'($urandom);
        wr(16'h8000);
        outs();
        chk(16'(chip_rst), 16'h0000);
        wr(16'h8000);
        chk(16'(chip_rst), 16'h0001);
        repeat (8) @(negedge mclk);
        rd(PBC_ADDR_CONTROL, ctl);
        outs();
        $display("done power-down");
        complete_run();
    end
endmodule : phy_basic_control_status_regs_bench
